// *** src/audio_path_router.sv ***
// digital audio router: adc formatting, main/low-latency/aux dac paths
// assumes tdm bit clock, frame sync and data arrive as pins from another domain
//
// What this block does
// - adc samples saturate, set overflow flag
// - one high-pass enable for all adcs
// - main channel source from any slot
// - main path group delay 100..450 us in 50 us steps
// - base-rate field sets delay length
// - channel mute/volume plus master attenuation
// - de-emphasis only single-speed 32/44.1/48k
// - de-emphasis coefficients from base rate
// - four low-latency slots bypass delay
// - low-latency global mute, per-channel invert
// - low-latency added after master volume
// - tracking holds max for group delay
// - config 10 selects internal tracking
// - only unmasked slots enter max
// - tracking enable disables aux invert
// - aux volume scales aux path
// - tracking offset added to envelope
// - config 00/01 passes external signal
// - tracking invert still applied in bypass
// - aux source slot or first-input lsbs
// - aux follows master when follow set
// - mask zero means unmasked
// - lowest slot index wins outside tracking
// - source 100 uses mask bits
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module audio_path_router
  import audio_path_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata_q,
  // tdm serial inputs (link)
  input  wire logic                  tdm_bit_clk,
  input  wire logic                  tdm_frame_sync,
  input  wire logic                  tdm_input_first,
  input  wire logic                  tdm_input_second,
  // adc samples
  input  wire logic [3:0]            adc_valid,
  input  wire logic [4*(SAMPLE_W+1)-1:0] adc_raw,
  output logic      [4*SAMPLE_W-1:0] adc_out_q,
  output logic                       highpass_enable,
  // dac outputs
  output logic      [4*SAMPLE_W-1:0] main_out_q,
  output logic      [SAMPLE_W-1:0]   aux_out_q,
  output logic                       frame_strobe_q,
  output logic                       deemph_active,
  output logic      [1:0]            deemph_coef_sel
);
  // register file
  logic [7:0] clock_port_q, adc_pwr_q, dac_pwr_q, adc_ctrl_q, group_dly_q, master_vol_q;
  logic [7:0] ch_mute_q, ll_ctrl_q, aux_ctrl_q, aux_vol_q, track_ctrl_q, status_q;
  logic [7:0] ch_vol_q [4];
  logic [7:0] ch_src_q [4];
  logic [7:0] ll_src_q [4];
  logic [7:0] mask_q   [4];
  logic [3:0] sel_vol, sel_src, sel_ll, sel_mask;
  logic       ovf_event;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dec
      assign sel_vol[g]  = reg_addr == A_CH_VOL0 + 8'(g);
      assign sel_src[g]  = reg_addr == A_CH_SRC0 + 8'(g);
      assign sel_ll[g]   = reg_addr == A_LL_SRC0 + 8'(g);
      assign sel_mask[g] = reg_addr == A_MASK0 + 8'(g);
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          ch_vol_q[g] <= 8'h00;
          ch_src_q[g] <= 8'(g);
          ll_src_q[g] <= 8'(g);
          mask_q[g]   <= 8'hff;
        end else if (clk_en && reg_wr) begin
          if (sel_vol[g])  ch_vol_q[g] <= reg_wdata;
          if (sel_src[g])  ch_src_q[g] <= reg_wdata;
          if (sel_ll[g])   ll_src_q[g] <= reg_wdata;
          if (sel_mask[g]) mask_q[g]   <= reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clock_port_q <= 8'h00;
      adc_pwr_q    <= PWR_RESET;
      dac_pwr_q    <= PWR_RESET;
      adc_ctrl_q   <= 8'h01;
      group_dly_q  <= 8'h00;
      master_vol_q <= 8'h00;
      ch_mute_q    <= 8'h00;
      ll_ctrl_q    <= 8'h00;
      aux_ctrl_q   <= 8'h10;
      aux_vol_q    <= 8'h00;
      track_ctrl_q <= 8'h00;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == A_CLOCK_PORT) clock_port_q <= reg_wdata;
      else if (reg_addr == A_ADC_PWR)    adc_pwr_q    <= reg_wdata;
      else if (reg_addr == A_DAC_PWR)    dac_pwr_q    <= reg_wdata;
      else if (reg_addr == A_ADC_CTRL)   adc_ctrl_q   <= reg_wdata;
      else if (reg_addr == A_GROUP_DLY)  group_dly_q  <= reg_wdata;
      else if (reg_addr == A_MASTER_VOL) master_vol_q <= reg_wdata;
      else if (reg_addr == A_CH_MUTE)    ch_mute_q    <= reg_wdata;
      else if (reg_addr == A_LL_CTRL)    ll_ctrl_q    <= reg_wdata;
      else if (reg_addr == A_AUX_CTRL)   aux_ctrl_q   <= reg_wdata;
      else if (reg_addr == A_AUX_VOL)    aux_vol_q    <= reg_wdata;
      else if (reg_addr == A_TRACK_CTRL) track_ctrl_q <= reg_wdata;
    end
  end

  // overflow flag: set wins over read-clear
  wire ovf_clear = reg_rd && reg_addr == A_STATUS;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) status_q <= 8'h00;
    else if (clk_en) begin
      if (ovf_event) status_q[F_OVF] <= 1'b1;
      else if (ovf_clear) status_q[F_OVF] <= 1'b0;
    end
  end

  wire [7:0] rd_mux =
    reg_addr == A_CLOCK_PORT ? clock_port_q :
    reg_addr == A_ADC_PWR    ? adc_pwr_q :
    reg_addr == A_DAC_PWR    ? dac_pwr_q :
    reg_addr == A_ADC_CTRL   ? adc_ctrl_q :
    reg_addr == A_GROUP_DLY  ? group_dly_q :
    reg_addr == A_MASTER_VOL ? master_vol_q :
    reg_addr == A_CH_MUTE    ? ch_mute_q :
    reg_addr == A_LL_CTRL    ? ll_ctrl_q :
    reg_addr == A_AUX_CTRL   ? aux_ctrl_q :
    reg_addr == A_AUX_VOL    ? aux_vol_q :
    reg_addr == A_TRACK_CTRL ? track_ctrl_q :
    reg_addr == A_STATUS     ? status_q :
    |sel_vol  ? ch_vol_q[reg_addr[1:0] - A_CH_VOL0[1:0]] :
    |sel_src  ? ch_src_q[reg_addr[1:0]] :
    |sel_ll   ? ll_src_q[reg_addr[1:0]] :
    |sel_mask ? mask_q[reg_addr[1:0]] : 8'h00;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) reg_rdata_q <= 8'h00;
    else if (clk_en) reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
  end

  // adc formatting with saturation
  assign highpass_enable = adc_ctrl_q[F_HPF];
  logic [3:0] clip;
  generate
    for (g = 0; g < 4; g++) begin : g_adc
      wire [SAMPLE_W:0] raw = adc_raw[g*(SAMPLE_W+1) +: SAMPLE_W+1];
      wire pos = !raw[SAMPLE_W] && raw[SAMPLE_W-1];
      wire neg = raw[SAMPLE_W] && !raw[SAMPLE_W-1];
      assign clip[g] = adc_valid[g] && (pos || neg);
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) adc_out_q[g*SAMPLE_W +: SAMPLE_W] <= '0;
        else if (clk_en && adc_valid[g])
          adc_out_q[g*SAMPLE_W +: SAMPLE_W] <= pos ? POS_FS : neg ? NEG_FS : raw[SAMPLE_W-1:0];
      end
    end
  endgenerate
  assign ovf_event = |clip;

  // link synchronisers
  logic [3:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else if (clk_en) begin
      sync1_q <= {tdm_bit_clk, tdm_frame_sync, tdm_input_first, tdm_input_second};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  wire bclk_rise = sync2_q[3] && !sync3_q[3];
  wire fs_rise   = sync2_q[2] && !sync3_q[2];

  // frame capture: shift both lines, then latch whole frame of 32 slots
  frame_state_e state_q;
  logic [FRAME_BITS/2-1:0] sh1_q, sh2_q;
  logic [FRAME_BITS-1:0]   frame_q;
  logic [FRAME_CNT_W-1:0]  bit_cnt_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= S_IDLE;
      sh1_q     <= '0;
      sh2_q     <= '0;
      frame_q   <= '0;
      bit_cnt_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        S_IDLE: if (fs_rise) begin
          state_q   <= S_SHIFT;
          bit_cnt_q <= '0;
        end
        S_SHIFT: if (bclk_rise) begin
          sh1_q     <= {sh1_q[FRAME_BITS/2-2:0], sync2_q[1]};
          sh2_q     <= {sh2_q[FRAME_BITS/2-2:0], sync2_q[0]};
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == FRAME_CNT_W'(FRAME_BITS/2-1)) state_q <= S_UPDATE;
        end
        S_UPDATE: begin
          frame_q <= {sh2_q, sh1_q};
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  wire frame_done = state_q == S_UPDATE;

  // slot k: first input slots 0..15, second input 16..31; slot 0 sent first
  function automatic logic [SAMPLE_W-1:0] slot_of(input logic [FRAME_BITS-1:0] f, input logic [SLOT_W-1:0] k);
    logic [3:0] i;
    i = k[3:0] ^ 4'hf;
    return k[4] ? f[FRAME_BITS/2 + i[3:0]*SAMPLE_W +: SAMPLE_W] : f[i[3:0]*SAMPLE_W +: SAMPLE_W];
  endfunction

  // volume: 9-bit attenuation in 6.02/16 db steps, approximated by shift and 16-step mantissa
  function automatic logic signed [SAMPLE_W-1:0] attenuate(input logic signed [SAMPLE_W-1:0] s,
                                                           input logic [8:0]                 att);
    logic signed [SAMPLE_W+1:0] m;
    m = s >>> att[8:4];
    return SAMPLE_W'(m - (m >>> 4) * $signed({1'b0, att[3:0]}) / 4);
  endfunction

  // group delay length in frames: delay_us * base / 1e6, delay_us 100..450 in 50 us steps, capped at 500 us
  wire [1:0] base_sel = clock_port_q[1:0];
  wire [9:0] gd_us = 10'(GD_MIN_US) + 10'(group_dly_q[2:0]) * 10'(GD_STEP_US);
  wire [9:0] gd_clamp = gd_us > 10'(GD_MAX_US) ? 10'(GD_MAX_US) : gd_us;
  wire [31:0] base_hz = base_sel == 2'd0 ? BASE_48K : base_sel == 2'd1 ? BASE_44K : BASE_32K;
  wire [DLY_AW-1:0] gd_frames = DLY_AW'((32'(gd_clamp) * base_hz) / 32'd1_000_000);

  // main path through delay memory
  logic [4*SAMPLE_W-1:0] main_sel, main_dly;
  logic [DLY_AW-1:0] wr_ptr_q;
  generate
    for (g = 0; g < 4; g++) begin : g_main
      assign main_sel[g*SAMPLE_W +: SAMPLE_W] = slot_of(frame_q, ch_src_q[g][SLOT_W-1:0]);
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) wr_ptr_q <= '0;
    else if (clk_en && frame_done) wr_ptr_q <= wr_ptr_q + 1'b1;
  end
  delay_mem u_dly (
    .ref_clk   (ref_clk),
    .clk_en    (clk_en),
    .wr_en     (frame_done),
    .wr_addr   (wr_ptr_q),
    .wr_data   (main_sel),
    .rd_addr   (wr_ptr_q - gd_frames),
    .rd_data_q (main_dly)
  );

  // de-emphasis only for single-speed base rates
  assign deemph_active   = adc_ctrl_q[F_DEEMPH] && !adc_ctrl_q[F_DOUBLE_SPD];
  assign deemph_coef_sel = base_sel;

  // tracking envelope: max abs over unmasked slots, hold for group delay
  logic [SLOTS-1:0] unmasked;
  assign unmasked = ~{mask_q[3], mask_q[2], mask_q[1], mask_q[0]};
  logic [SAMPLE_W-1:0] frame_max, first_pick;
  always_comb begin
    logic [SAMPLE_W-1:0] s, a;
    logic found;
    s = '0;
    a = '0;
    found = 1'b0;
    frame_max = '0;
    first_pick = '0;
    for (int k = 0; k < SLOTS; k++) begin
      s = slot_of(frame_q, SLOT_W'(k));
      a = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
      if (unmasked[k] && a > frame_max) frame_max = a;
      if (unmasked[k] && !found) begin
        first_pick = s;
        found = 1'b1;
      end
    end
  end
  logic [SAMPLE_W-1:0] env_q;
  logic [DLY_AW-1:0]   hold_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      env_q  <= '0;
      hold_q <= '0;
    end else if (clk_en && frame_done) begin
      if (frame_max >= env_q || hold_q == '0) begin
        env_q  <= frame_max;
        hold_q <= gd_frames;
      end else hold_q <= hold_q - 1'b1;
    end
  end

  // aux path
  wire [1:0] aux_cfg = aux_ctrl_q[F_AUX_CFG +: 2];
  wire [2:0] aux_src = aux_ctrl_q[F_AUX_SRC +: 3];
  logic [SAMPLE_W-1:0] lsb_word;
  generate
    for (g = 0; g < 16; g++) begin : g_lsb
      wire [SAMPLE_W-1:0] word = slot_of(frame_q, SLOT_W'(g));
      assign lsb_word[SAMPLE_W-1-g] = word[0];
    end
  endgenerate
  assign lsb_word[SAMPLE_W-17:0] = '0;
  wire [SAMPLE_W-1:0] ext_sig = aux_src == SRC_LSBS ? lsb_word :
                                aux_src == SRC_MASK ? first_pick : slot_of(frame_q, SLOT_W'(aux_src));
  wire [SAMPLE_W-1:0] trk_sig = env_q + OFS_STEP * track_ctrl_q[F_TRK_OFS +: 3];
  wire [SAMPLE_W-1:0] aux_pre = aux_cfg == CFG_TRACK ? trk_sig : ext_sig;
  wire inv_aux = !track_ctrl_q[F_TRK_EN] && aux_ctrl_q[F_AUX_INV];
  wire inv_trk = track_ctrl_q[F_TRK_INV];
  wire [SAMPLE_W-1:0] aux_inv = (inv_aux ^ inv_trk) ? SAMPLE_W'(-aux_pre) : aux_pre;
  wire [8:0] aux_att = 9'(aux_vol_q) + (aux_ctrl_q[F_AUX_MVC] ? 9'(master_vol_q) : 9'h0);

  // outputs at frame rate
  logic [4*SAMPLE_W-1:0] main_mix;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      main_out_q     <= '0;
      aux_out_q      <= '0;
      frame_strobe_q <= 1'b0;
    end else if (clk_en) begin
      frame_strobe_q <= frame_done;
      if (frame_done) aux_out_q <= dac_pwr_q[4] ? '0 : attenuate(aux_inv, aux_att);
      if (frame_done) main_out_q <= main_mix;
    end
  end

  generate
    for (g = 0; g < 4; g++) begin : g_mix
      wire [SAMPLE_W-1:0] ll_raw = slot_of(frame_q, ll_src_q[g][SLOT_W-1:0]);
      wire [SAMPLE_W-1:0] ll_sig = ll_ctrl_q[F_LL_MUTE] ? '0 : ll_ctrl_q[g] ? SAMPLE_W'(-ll_raw) : ll_raw;
      wire [8:0] att = 9'(ch_vol_q[g]) + 9'(master_vol_q);
      wire [SAMPLE_W-1:0] vol = (ch_mute_q[g] || dac_pwr_q[g]) ? '0 :
                                attenuate(main_dly[g*SAMPLE_W +: SAMPLE_W], att);
      assign main_mix[g*SAMPLE_W +: SAMPLE_W] = vol + ll_sig;
    end
  endgenerate

  a_adc_clip_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && ovf_event |=> status_q[F_OVF]) else $error("overflow flag not set");
  a_ovf_read_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && ovf_clear && !ovf_event |=> !status_q[F_OVF]) else $error("overflow flag not cleared by read");
  a_deemph_single: assert property (@(posedge ref_clk) disable iff (!resetn)
    adc_ctrl_q[F_DOUBLE_SPD] |-> !deemph_active) else $error("de-emphasis in double speed");
  a_env_hold_max: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && frame_done && frame_max >= env_q |=> env_q == $past(frame_max)) else $error("envelope not raised");
  a_strobe_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && frame_done |=> frame_strobe_q) else $error("frame strobe missing");
  a_aux_inv_block: assert property (@(posedge ref_clk) disable iff (!resetn)
    track_ctrl_q[F_TRK_EN] |-> !inv_aux) else $error("aux invert active under tracking");
  a_mute_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    ll_ctrl_q[F_LL_MUTE] && clk_en && frame_done && ch_mute_q[0] |=> main_out_q[SAMPLE_W-1:0] == '0)
    else $error("muted channel not silent");
  a_rd_data_next: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && reg_rd && reg_addr == A_MASTER_VOL |=> reg_rdata_q == $past(master_vol_q)) else $error("read data wrong");
  c_frame: cover property (@(posedge ref_clk) disable iff (!resetn) frame_done);
  c_clip: cover property (@(posedge ref_clk) disable iff (!resetn) ovf_event);
  c_track: cover property (@(posedge ref_clk) disable iff (!resetn) aux_cfg == CFG_TRACK && frame_done);
endmodule

// *** src/audio_path_pkg.sv ***
// constants for the codec digital audio path: register map, fields, timing
// assumes a 50 mhz ref_clk and 24-bit samples arriving over two 16-slot tdm lines
package audio_path_pkg;
  localparam int CLK_HZ      = 50_000_000;
  localparam int SAMPLE_W    = 24;
  localparam int SLOTS       = 32;
  localparam int SLOT_W      = 5;
  localparam int FRAME_BITS  = SLOTS * SAMPLE_W;
  localparam int FRAME_CNT_W = 10;
  // group delay range in microseconds
  localparam int GD_MIN_US   = 100;
  localparam int GD_MAX_US   = 500;
  localparam int GD_STEP_US  = 50;
  // base rates in hz selected by clock_port_select[1:0]
  localparam int BASE_32K    = 32_000;
  localparam int BASE_44K    = 44_100;
  localparam int BASE_48K    = 48_000;
  localparam int DLY_DEPTH   = 32;
  localparam int DLY_AW      = 5;
  // register offsets
  localparam logic [7:0] A_CLOCK_PORT = 8'h06;
  localparam logic [7:0] A_ADC_PWR    = 8'h10;
  localparam logic [7:0] A_DAC_PWR    = 8'h15;
  localparam logic [7:0] A_ADC_CTRL   = 8'h20;
  localparam logic [7:0] A_GROUP_DLY  = 8'h21;
  localparam logic [7:0] A_MASTER_VOL = 8'h22;
  localparam logic [7:0] A_CH_VOL0    = 8'h23;
  localparam logic [7:0] A_CH_MUTE    = 8'h27;
  localparam logic [7:0] A_CH_SRC0    = 8'h28;
  localparam logic [7:0] A_LL_SRC0    = 8'h2c;
  localparam logic [7:0] A_LL_CTRL    = 8'h30;
  localparam logic [7:0] A_AUX_CTRL   = 8'h31;
  localparam logic [7:0] A_AUX_VOL    = 8'h32;
  localparam logic [7:0] A_TRACK_CTRL = 8'h33;
  localparam logic [7:0] A_MASK0      = 8'h34;
  localparam logic [7:0] A_STATUS     = 8'h38;
  localparam logic [7:0] PWR_RESET    = 8'hff;
  // field positions
  localparam int F_HPF        = 0;
  localparam int F_DEEMPH     = 1;
  localparam int F_DOUBLE_SPD = 2;
  localparam int F_LL_MUTE    = 4;
  localparam int F_AUX_CFG    = 0;
  localparam int F_AUX_SRC    = 2;
  localparam int F_AUX_MVC    = 5;
  localparam int F_AUX_INV    = 6;
  localparam int F_TRK_OFS    = 0;
  localparam int F_TRK_INV    = 3;
  localparam int F_TRK_EN     = 4;
  localparam int F_OVF        = 0;
  localparam logic [1:0] CFG_INTERP = 2'b00;
  localparam logic [1:0] CFG_SAMPLE = 2'b01;
  localparam logic [1:0] CFG_TRACK  = 2'b10;
  localparam logic [2:0] SRC_MASK   = 3'b100;
  localparam logic [2:0] SRC_LSBS   = 3'b101;
  localparam logic [23:0] POS_FS = 24'h7fffff;
  localparam logic [23:0] NEG_FS = 24'h800000;
  localparam logic [SAMPLE_W-1:0] OFS_STEP = 24'h010000;
  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_SHIFT  = 3'b010,
    S_UPDATE = 3'b100
  } frame_state_e;
endpackage

// *** src/delay_mem.sv ***
// single-port-per-side delay memory for four frame-rate sample words, one per channel
// assumes writes and reads occur in the same clock domain
`timescale 1ns/1ps
module delay_mem
  import audio_path_pkg::*;
(
  // clock
  input  wire logic                    ref_clk,
  input  wire logic                    clk_en,
  // write side
  input  wire logic                    wr_en,
  input  wire logic [DLY_AW-1:0]       wr_addr,
  input  wire logic [4*SAMPLE_W-1:0]   wr_data,
  // read side
  input  wire logic [DLY_AW-1:0]       rd_addr,
  output logic      [4*SAMPLE_W-1:0]   rd_data_q
);
  logic [4*SAMPLE_W-1:0] mem [DLY_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (clk_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule

// *** testbench/tdm_host_model.sv ***
// tdm serial host model: two 16-slot lines, 24-bit slots, msb first
// assumes the bench loads slot_q before each send_frame call
`timescale 1ns/1ps
module tdm_host_model (
  // link pins
  output logic tdm_bit_clk,
  output logic tdm_frame_sync,
  output logic tdm_input_first,
  output logic tdm_input_second
);
  logic [23:0] slot_q [32];

  initial begin
    tdm_bit_clk = 1'b0;
    tdm_frame_sync = 1'b0;
    tdm_input_first = 1'b1;
    tdm_input_second = 1'b1;
  end

  // bit clock runs only inside a frame, 160 ns period
  task automatic send_frame();
    for (int b = 0; b < 384; b++) begin
      tdm_frame_sync = (b == 0);
      tdm_input_first = slot_q[b / 24][23 - b % 24];
      tdm_input_second = slot_q[16 + b / 24][23 - b % 24];
      #80 tdm_bit_clk = 1'b1;
      #80 tdm_bit_clk = 1'b0;
    end
    // released lines show the inverse of the last bit
    tdm_input_first = ~tdm_input_first;
    tdm_input_second = ~tdm_input_second;
    #400;
  endtask
endmodule

// *** testbench/test_audio_path_router.sv ***
// self-checking bench: registers, adc clip, main, low-latency and aux paths
// assumes slot index = line * 16 + slot and a zero volume code is unity gain
`timescale 1ns/1ps
module test_audio_path_router
  import audio_path_pkg::*;
;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;
  logic                      ref_clk, resetn, clk_en, reg_wr, reg_rd;
  logic [7:0]                reg_addr, reg_wdata, reg_rdata_q;
  logic                      tdm_bit_clk, tdm_frame_sync, tdm_input_first, tdm_input_second;
  logic [3:0]                adc_valid;
  logic [4*(SAMPLE_W+1)-1:0] adc_raw;
  logic [4*SAMPLE_W-1:0]     adc_out_q, main_out_q;
  logic [SAMPLE_W-1:0]       aux_out_q;
  logic                      highpass_enable, frame_strobe_q, deemph_active;
  logic [1:0]                deemph_coef_sel;
  int                        mismatches, samples_checked, strobes;
  row_s                      rows [7] = '{'{A_ADC_CTRL, 8'h00, 8'h00}, '{A_GROUP_DLY, 8'h00, 8'h00},
    '{A_CLOCK_PORT, 8'h00, 8'h00}, '{A_CH_SRC0, 8'h03, 8'h03}, '{A_LL_SRC0, 8'h07, 8'h07},
    '{A_LL_CTRL, 8'h10, 8'h10}, '{8'h3f, 8'h5a, 8'h00}};

  audio_path_router uut (.ref_clk, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .tdm_bit_clk, .tdm_frame_sync, .tdm_input_first, .tdm_input_second, .adc_valid, .adc_raw, .adc_out_q,
    .highpass_enable, .main_out_q, .aux_out_q, .frame_strobe_q, .deemph_active, .deemph_coef_sel);
  tdm_host_model host (.tdm_bit_clk, .tdm_frame_sync, .tdm_input_first, .tdm_input_second);

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (frame_strobe_q === 1'b1) strobes++;

  task automatic chk(input logic [23:0] got, input logic [23:0] e);
    samples_checked++;
    if (got !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk({16'h0, reg_rdata_q}, {16'h0, e});
  endtask
  task automatic adc(input logic [24:0] raw, input logic [23:0] e);
    @(posedge ref_clk);
    adc_valid <= 4'h1;
    adc_raw[24:0] <= raw;
    @(posedge ref_clk);
    adc_valid <= 4'h0;
    #1 chk(adc_out_q[23:0], e);
  endtask
  task automatic frames(input int n);
    int s;
    s = strobes + n;
    repeat (n) host.send_frame();
    for (int k = 0; k < 200 && strobes < s; k++) @(posedge ref_clk);
    #1;
    if (strobes < s) begin
      mismatches++;
      $display("MISMATCH t=%0t frame strobe missing", $time);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #1_900_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    adc_valid = 4'h0;
    adc_raw = '0;
    foreach (host.slot_q[i]) host.slot_q[i] = 24'h0;
    host.slot_q[3] = 24'h100000;
    host.slot_q[5] = 24'h000001;
    host.slot_q[7] = 24'h070000;
    host.slot_q[20] = 24'hd00000;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    settle();
    chk({23'h0, highpass_enable}, 24'h0);
    // second reset in mid-run
    resetn <= 1'b0;
    settle();
    resetn <= 1'b1;
    settle();
    chk({23'h0, highpass_enable}, 24'h1);
    rd(A_MASK0, 8'hff);
    rd(A_DAC_PWR, PWR_RESET);
    rd(A_AUX_CTRL, 8'h10);
    for (int r = 0; r < 3; r++) begin
      wr(A_CLOCK_PORT, 8'(r));
      wr(A_ADC_CTRL, 8'h02);
      settle();
      chk({22'h0, deemph_coef_sel}, 24'(r));
      chk({23'h0, deemph_active}, 24'h1);
      wr(A_ADC_CTRL, 8'h06);
      settle();
      chk({23'h0, deemph_active}, 24'h0);
    end
    wr(A_CLOCK_PORT, 8'h00);
    wr(A_ADC_CTRL, 8'h01);
    adc(25'h0800000, POS_FS);
    rd(A_STATUS, 8'h01);
    rd(A_STATUS, 8'h00);
    adc(25'h17fffff, NEG_FS);
    adc(25'h0012345, 24'h012345);
    rd(A_STATUS, 8'h01);
    wr(A_DAC_PWR, 8'h00);
    wr(A_CH_SRC0, 8'h03);
    wr(A_LL_SRC0, 8'h07);
    wr(A_LL_CTRL, 8'h10);
    frames(6);
    chk(main_out_q[23:0], 24'h100000);
    wr(A_CH_MUTE, 8'h01);
    frames(2);
    chk(main_out_q[23:0], 24'h0);
    wr(A_CH_MUTE, 8'h00);
    wr(A_MASTER_VOL, 8'h10);
    rd(A_MASTER_VOL, 8'h10);
    wr(A_LL_CTRL, 8'h00);
    frames(2);
    chk(main_out_q[23:0], 24'h0f0000);
    wr(A_LL_CTRL, 8'h01);
    frames(2);
    chk(main_out_q[23:0], 24'h010000);
    wr(A_MASK0, 8'hf7);
    wr(A_MASK0 + 8'h02, 8'hef);
    for (int c = 0; c < 2; c++) begin
      wr(A_AUX_CTRL, 8'h10 | 8'(c));
      wr(A_TRACK_CTRL, 8'(c) << 3);
      frames(2);
      chk(aux_out_q, c ? 24'hf00000 : 24'h100000);
    end
    wr(A_TRACK_CTRL, 8'h00);
    wr(A_AUX_CTRL, 8'h30);
    frames(2);
    chk(aux_out_q, 24'h080000);
    wr(A_AUX_CTRL, 8'h14);
    frames(2);
    chk(aux_out_q, 24'h040000);
    wr(A_AUX_CTRL, 8'h10);
    wr(A_AUX_VOL, 8'h10);
    frames(2);
    chk(aux_out_q, 24'h080000);
    wr(A_AUX_VOL, 8'h00);
    wr(A_AUX_CTRL, 8'h52);
    wr(A_TRACK_CTRL, 8'h10);
    frames(2);
    chk(aux_out_q, 24'h300000);
    wr(A_TRACK_CTRL, 8'h11);
    frames(2);
    chk(aux_out_q, 24'h310000);
    give_verdict();
  end
endmodule
